// *** sbtc_host.sv ***
// Behavioural host model that drives the register port of the configuration bank.
`timescale 1ns/100ps
module sbtc_host_model (
  // Clock.
  input  wire logic        core_clk,
  // Register access port towards the bank.
  output logic             reg_wr_en,
  output logic      [7:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             last_message_rejected
);
  // Idle values at time zero.
  initial
  begin
    reg_wr_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    last_message_rejected = 1'b0;
  end
  // One strobe per word; callers hand in legal settings, apart from one write to the unmapped address 1c hex.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
    reg_wdata = ~d; // A released bus shows the inverse, never the old word.
  endtask : wr
  // Reads are combinational, so the word settles a moment after the address.
  task automatic rd(input logic [7:0] a, input logic lmr);
    @(negedge core_clk);
    reg_addr = a;
    last_message_rejected = lmr;
    #1;
  endtask : rd
endmodule : sbtc_host_model

// *** sbtc_pkg.sv ***
// Package with offsets, field positions and reset values of the turn-off configuration bank.
package sbtc_pkg;

  // Register offsets (word addresses on the internal register port).
  localparam logic [7:0] OFS_OVERCURRENT_BLANKING_CONFIG  = 8'h19;
  localparam logic [7:0] OFS_REGULAR_TURNOFF_DELAY_CONFIG = 8'h1a;
  localparam logic [7:0] OFS_SAFE_TURNOFF_DELAY_CONFIG    = 8'h1b;

  // Reset values of the stored words.
  localparam logic [15:0] RST_OVERCURRENT_BLANKING_CONFIG  = 16'h0001;
  localparam logic [15:0] RST_REGULAR_TURNOFF_DELAY_CONFIG = 16'h0001;
  localparam logic [15:0] RST_SAFE_TURNOFF_DELAY_CONFIG    = 16'h2000;

  // Field positions.
  localparam int DELAY_MSB   = 15;
  localparam int DELAY_LSB   = 8;
  localparam int PLATEAU_MSB = 7;
  localparam int PLATEAU_LSB = 4;
  localparam int NOTIFY_BIT  = 1;
  localparam int PARITY_BIT  = 0;

  // Host-side programming limits, used only as testbench write data.
  localparam logic [7:0] OCP_BLANK_MAX      = 8'h2f;
  localparam logic [7:0] REGULAR_DELAY_MIN  = 8'h02;
  localparam logic [7:0] SAFE_DELAY_MIN     = 8'h0a;

endpackage : sbtc_pkg

// *** sbtc_regs.sv ***
// Secondary-side blanking and two-level turn-off configuration registers.
// Functional notes
// (R01) Holds an 8-bit overcurrent blanking time in bits 15:8 and drives it to the monitor.
// (R02) A zero blanking value switches off digital blanking generation for the monitor.
// (R03) The host never writes a blanking value above 2F hex.
// (R04) Holds an 8-bit regular turn-off delay in bits 15:8; zero disables regular two-level off.
// (R05) The host programs a regular delay of at least 2 when that function is used.
// (R06) Holds an 8-bit safe turn-off delay in bits 15:8; zero disables safe two-level off.
// (R07) The host programs a safe delay of at least A hex when that function is used.
// (R08) The host should keep the safe delay at zero in operating modes five and six.
// (R09) In operating mode four the safe delay must exceed the regular delay.
// (R10) Holds a 4-bit safe plateau voltage select in bits 7:4, coded like the regular one.
// (R11) Reserved bit positions read back as zero.
// (R12) Bit 1 of each word returned for a mapped address is one when the previous message was discarded.
// (R13) Bit 0 of each word returned for a mapped address is odd parity over the word.
// (R14) Writes touch only the writable fields; reserved, notice and parity bits are ignored.
`timescale 1ns/100ps
module sbtc_regs (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Register access port from the serial message decoder.
  input  wire logic        reg_wr_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             reg_hit,
  // Status of the previous serial message.
  input  wire logic        last_message_rejected,
  // Settings towards the protection and turn-off logic.
  output logic      [7:0]  ocp_blank_cycles,
  output logic             ocp_blank_enable,
  output logic      [7:0]  regular_soft_off_delay,
  output logic             regular_two_level_enable,
  output logic      [7:0]  safe_soft_off_delay,
  output logic             safe_two_level_enable,
  output logic      [3:0]  safe_plateau_voltage_sel
);

  logic [7:0] ocp_blank_ff,   nxt_ocp_blank;
  logic [7:0] reg_delay_ff,   nxt_reg_delay;
  logic [7:0] safe_delay_ff,  nxt_safe_delay;
  logic [3:0] plateau_ff,     nxt_plateau;
  logic [15:0] rd_word;

  // Write decode: only the rw fields are taken from the write data. [R14]
  always_comb
  begin
    nxt_ocp_blank  = ocp_blank_ff;
    nxt_reg_delay  = reg_delay_ff;
    nxt_safe_delay = safe_delay_ff;
    nxt_plateau    = plateau_ff;
    if (sys_rst)
    begin
      nxt_ocp_blank  = sbtc_pkg::RST_OVERCURRENT_BLANKING_CONFIG[15:8];
      nxt_reg_delay  = sbtc_pkg::RST_REGULAR_TURNOFF_DELAY_CONFIG[15:8];
      nxt_safe_delay = sbtc_pkg::RST_SAFE_TURNOFF_DELAY_CONFIG[15:8];
      nxt_plateau    = sbtc_pkg::RST_SAFE_TURNOFF_DELAY_CONFIG[7:4];
    end
    else if (reg_wr_en)
    begin
      unique case (reg_addr)
        sbtc_pkg::OFS_OVERCURRENT_BLANKING_CONFIG:
          nxt_ocp_blank = reg_wdata[sbtc_pkg::DELAY_MSB:sbtc_pkg::DELAY_LSB]; // [R01]
        sbtc_pkg::OFS_REGULAR_TURNOFF_DELAY_CONFIG:
          nxt_reg_delay = reg_wdata[sbtc_pkg::DELAY_MSB:sbtc_pkg::DELAY_LSB]; // [R04]
        sbtc_pkg::OFS_SAFE_TURNOFF_DELAY_CONFIG:
        begin
          nxt_safe_delay = reg_wdata[sbtc_pkg::DELAY_MSB:sbtc_pkg::DELAY_LSB];     // [R06]
          nxt_plateau    = reg_wdata[sbtc_pkg::PLATEAU_MSB:sbtc_pkg::PLATEAU_LSB]; // [R10]
        end
        default:
          nxt_ocp_blank = ocp_blank_ff;
      endcase
    end
  end

  // Storage registers; the synchronous reset is folded into the next-state logic.
  always_ff @(posedge core_clk)
  begin
    ocp_blank_ff  <= nxt_ocp_blank;
    reg_delay_ff  <= nxt_reg_delay;
    safe_delay_ff <= nxt_safe_delay;
    plateau_ff    <= nxt_plateau;
  end

  // Settings out; a zero count means the feature is off, so consumers need no compare.
  assign ocp_blank_cycles         = ocp_blank_ff;           // [R01]
  assign ocp_blank_enable         = |ocp_blank_ff;          // [R02]
  assign regular_soft_off_delay   = reg_delay_ff;           // [R04]
  assign regular_two_level_enable = |reg_delay_ff;          // [R04]
  assign safe_soft_off_delay      = safe_delay_ff;          // [R06]
  assign safe_two_level_enable    = |safe_delay_ff;         // [R06]
  assign safe_plateau_voltage_sel = plateau_ff;             // [R10]

  // Read word: fields, zero reserved bits, notice bit, then odd parity in bit 0.
  always_comb
  begin
    rd_word = 16'h0000; // [R11]
    reg_hit = 1'b1;
    unique case (reg_addr)
      sbtc_pkg::OFS_OVERCURRENT_BLANKING_CONFIG:
        rd_word[sbtc_pkg::DELAY_MSB:sbtc_pkg::DELAY_LSB] = ocp_blank_ff;   // [R01]
      sbtc_pkg::OFS_REGULAR_TURNOFF_DELAY_CONFIG:
        rd_word[sbtc_pkg::DELAY_MSB:sbtc_pkg::DELAY_LSB] = reg_delay_ff;   // [R04]
      sbtc_pkg::OFS_SAFE_TURNOFF_DELAY_CONFIG:
      begin
        rd_word[sbtc_pkg::DELAY_MSB:sbtc_pkg::DELAY_LSB]     = safe_delay_ff; // [R06]
        rd_word[sbtc_pkg::PLATEAU_MSB:sbtc_pkg::PLATEAU_LSB] = plateau_ff;    // [R10]
      end
      default:
        reg_hit = 1'b0;
    endcase
    rd_word[sbtc_pkg::NOTIFY_BIT] = reg_hit & last_message_rejected; // [R12]
    // On a mapped address parity is odd across all 16 bits, so bit 0 makes the total count of ones odd.
    rd_word[sbtc_pkg::PARITY_BIT] = reg_hit & ~(^rd_word[15:1]);   // [R13]
    reg_rdata = rd_word;
  end

  // Blanking output follows the stored field one cycle after a write.
  property p_ocp_write;
    @(posedge core_clk) disable iff (sys_rst)
      (reg_wr_en && reg_addr == sbtc_pkg::OFS_OVERCURRENT_BLANKING_CONFIG)
      |=> (ocp_blank_cycles == $past(reg_wdata[15:8])
           && ocp_blank_enable == ($past(reg_wdata[15:8]) != 8'h00));
  endproperty
  a_ocp_write: assert property (p_ocp_write) else $error("Blanking field not updated."); // [R01]

  // A zero written to the blanking field must switch blanking off on the next cycle.
  property p_ocp_zero;
    @(posedge core_clk) disable iff (sys_rst)
      (reg_wr_en && reg_addr == sbtc_pkg::OFS_OVERCURRENT_BLANKING_CONFIG
       && reg_wdata[15:8] == 8'h00) |=> !ocp_blank_enable;
  endproperty
  a_ocp_zero: assert property (p_ocp_zero) else $error("Blanking active at zero."); // [R02]

  property p_reg_delay;
    @(posedge core_clk) disable iff (sys_rst)
      (reg_wr_en && reg_addr == sbtc_pkg::OFS_REGULAR_TURNOFF_DELAY_CONFIG)
      |=> (regular_soft_off_delay == $past(reg_wdata[15:8])
           && regular_two_level_enable == ($past(reg_wdata[15:8]) != 8'h00));
  endproperty
  a_reg_delay: assert property (p_reg_delay) else $error("Regular delay wrong."); // [R04]

  property p_safe_delay;
    @(posedge core_clk) disable iff (sys_rst)
      (reg_wr_en && reg_addr == sbtc_pkg::OFS_SAFE_TURNOFF_DELAY_CONFIG)
      |=> (safe_soft_off_delay == $past(reg_wdata[15:8])
           && safe_two_level_enable == ($past(reg_wdata[15:8]) != 8'h00));
  endproperty
  a_safe_delay: assert property (p_safe_delay) else $error("Safe delay wrong."); // [R06]

  property p_plateau;
    @(posedge core_clk) disable iff (sys_rst)
      (reg_wr_en && reg_addr == sbtc_pkg::OFS_SAFE_TURNOFF_DELAY_CONFIG)
      |=> safe_plateau_voltage_sel == $past(reg_wdata[7:4]);
  endproperty
  a_plateau: assert property (p_plateau) else $error("Plateau select wrong."); // [R10]

  property p_reserved;
    @(posedge core_clk) disable iff (sys_rst)
      (reg_addr == sbtc_pkg::OFS_SAFE_TURNOFF_DELAY_CONFIG) ? (reg_rdata[3:2] == 2'b00)
                                                             : (reg_rdata[7:2] == 6'h00);
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved bits not zero."); // [R11]

  property p_notify;
    @(posedge core_clk) disable iff (sys_rst)
      reg_hit |-> reg_rdata[1] == last_message_rejected;
  endproperty
  a_notify: assert property (p_notify) else $error("Notice bit wrong."); // [R12]

  property p_parity;
    @(posedge core_clk) disable iff (sys_rst)
      reg_hit |-> (^reg_rdata) == 1'b1;
  endproperty
  a_parity: assert property (p_parity) else $error("Parity not odd."); // [R13]

  property p_ignore;
    @(posedge core_clk) disable iff (sys_rst)
      !reg_wr_en |=> $stable(ocp_blank_cycles) && $stable(regular_soft_off_delay)
                     && $stable(safe_soft_off_delay) && $stable(safe_plateau_voltage_sel);
  endproperty
  a_ignore: assert property (p_ignore) else $error("Field changed without write."); // [R14]

  // A write to an unmapped address must not reach any stored field.
  property p_unmapped_write;
    @(posedge core_clk) disable iff (sys_rst)
      (reg_wr_en && !reg_hit)
      |=> $stable(ocp_blank_cycles) && $stable(regular_soft_off_delay)
          && $stable(safe_soft_off_delay) && $stable(safe_plateau_voltage_sel);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("Unmapped write landed."); // [R14]

  // Writes to the other two words must leave the safe fields alone.
  property p_other_keep;
    @(posedge core_clk) disable iff (sys_rst)
      (reg_wr_en && reg_addr != sbtc_pkg::OFS_SAFE_TURNOFF_DELAY_CONFIG)
      |=> $stable(safe_soft_off_delay) && $stable(safe_plateau_voltage_sel);
  endproperty
  a_other_keep: assert property (p_other_keep) else $error("Safe fields disturbed."); // [R14]

  // Synchronous reset loads the reset fields; blanking is therefore off after reset.
  property p_reset_fields;
    @(posedge core_clk)
      sys_rst |=>
        (ocp_blank_cycles == sbtc_pkg::RST_OVERCURRENT_BLANKING_CONFIG[15:8]
         && regular_soft_off_delay == sbtc_pkg::RST_REGULAR_TURNOFF_DELAY_CONFIG[15:8]
         && safe_soft_off_delay == sbtc_pkg::RST_SAFE_TURNOFF_DELAY_CONFIG[15:8]
         && safe_plateau_voltage_sel == sbtc_pkg::RST_SAFE_TURNOFF_DELAY_CONFIG[7:4]);
  endproperty
  a_reset_fields: assert property (p_reset_fields) else $error("Reset fields wrong."); // [R02]

  // Read data carries the stored delay or blanking field of the addressed word.
  property p_read_back;
    @(posedge core_clk) disable iff (sys_rst)
      reg_hit |-> reg_rdata[15:8] ==
        ((reg_addr == sbtc_pkg::OFS_OVERCURRENT_BLANKING_CONFIG) ? ocp_blank_cycles :
         (reg_addr == sbtc_pkg::OFS_REGULAR_TURNOFF_DELAY_CONFIG) ? regular_soft_off_delay :
         safe_soft_off_delay);
  endproperty
  a_read_back: assert property (p_read_back) else $error("Read field wrong."); // [R01]

  // The plateau select reads back from bits 7:4 of the safe word only.
  property p_plateau_read;
    @(posedge core_clk) disable iff (sys_rst)
      (reg_addr == sbtc_pkg::OFS_SAFE_TURNOFF_DELAY_CONFIG)
      |-> reg_rdata[7:4] == safe_plateau_voltage_sel;
  endproperty
  a_plateau_read: assert property (p_plateau_read) else $error("Plateau read wrong."); // [R10]

  // An unmapped address returns an all-zero word, notice and parity included.
  property p_unmapped_read;
    @(posedge core_clk) disable iff (sys_rst)
      !reg_hit |-> reg_rdata == 16'h0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("Unmapped read not zero."); // [R11]

endmodule : sbtc_regs

// *** tb_secondary_blanking_turnoff_config.sv ***
// Self-checking testbench of the turn-off configuration bank.
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_secondary_blanking_turnoff_config;
  logic        core_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        reg_wr_en, reg_hit, lmr, blk_en, reg_en, saf_en;
  logic [7:0]  reg_addr, blk, rgd, sfd;
  logic [15:0] reg_wdata, reg_rdata;
  logic [3:0]  plat;
  int          miscompares = 0;
  int          n_compared = 0;
  sbtc_host_model host (.core_clk(core_clk), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .last_message_rejected(lmr));
  sbtc_regs DUT (.core_clk(core_clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .last_message_rejected(lmr), .ocp_blank_cycles(blk), .ocp_blank_enable(blk_en),
    .regular_soft_off_delay(rgd), .regular_two_level_enable(reg_en),
    .safe_soft_off_delay(sfd), .safe_two_level_enable(saf_en),
    .safe_plateau_voltage_sel(plat));
  // Free-running 200 MHz clock.
  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end
  // Expected word: stored fields, notice bit, then odd parity over the rest.
  function automatic logic [15:0] word(input logic [15:0] w, input logic l);
    logic [15:0] v;
    v = {w[15:2], l, 1'b0};
    v[0] = ~^v[15:1];
    return v;
  endfunction : word
  task automatic chk_rd(input logic [7:0] a, input logic [15:0] w, input logic l);
    host.rd(a, l);
    `CHK("reg_rdata", word(w, l), reg_rdata)
    `CHK("reg_hit", 1'b1, reg_hit)
  endtask : chk_rd
  task automatic chk_set(input logic [7:0] b, input logic [7:0] r, input logic [7:0] s,
                         input logic [3:0] p);
    `CHK("ocp_blank", {b, b != 8'h00}, {blk, blk_en})
    `CHK("regular", {r, r != 8'h00}, {rgd, reg_en})
    `CHK("safe", {s, s != 8'h00}, {sfd, saf_en})
    `CHK("plateau", p, plat)
  endtask : chk_set
  // Reset values read back with correct fields and parity.
  task automatic t_reset;
    chk_rd(8'h19, 16'h0000, 1'b0);
    chk_rd(8'h1a, 16'h0000, 1'b0);
    chk_rd(8'h1b, 16'h2000, 1'b0);
    chk_set(8'h00, 8'h00, 8'h20, 4'h0);
  endtask : t_reset
  // Writes with one idle cycle between them, every reserved, notice and parity bit set.
  task automatic t_write;
    host.wr(8'h1a, {sbtc_pkg::REGULAR_DELAY_MIN, 8'hff});
    host.wr(8'h19, {sbtc_pkg::OCP_BLANK_MAX, 8'hff});
    host.wr(8'h1b, {sbtc_pkg::SAFE_DELAY_MIN, 8'hff});
    chk_rd(8'h19, 16'h2f00, 1'b0);
    chk_rd(8'h1a, 16'h0200, 1'b0);
    chk_rd(8'h1b, 16'h0af0, 1'b1);
    chk_set(8'h2f, 8'h02, 8'h0a, 4'hf);
  endtask : t_write
  // Unmapped address is refused, then zero disables every function.
  task automatic t_zero;
    host.wr(8'h1c, 16'hffff);
    host.rd(8'h1c, 1'b1);
    `CHK("unmapped", 17'h0_0000, {reg_hit, reg_rdata})
    chk_set(8'h2f, 8'h02, 8'h0a, 4'hf);
    host.wr(8'h19, 16'h0000);
    host.wr(8'h1a, 16'h0000);
    host.wr(8'h1b, 16'h0050);
    chk_set(8'h00, 8'h00, 8'h00, 4'h5);
    chk_rd(8'h1b, 16'h0050, 1'b1);
  endtask : t_zero
  // Reset in mid-run brings back the reset fields after a fresh setting.
  task automatic t_rerst;
    host.wr(8'h19, 16'h1500);
    chk_set(8'h15, 8'h00, 8'h00, 4'h5);
    @(negedge core_clk);
    sys_rst = 1'b1;
    @(negedge core_clk);
    sys_rst = 1'b0;
    chk_set(8'h00, 8'h00, 8'h20, 4'h0);
    chk_rd(8'h1b, 16'h2000, 1'b0);
  endtask : t_rerst
  task automatic print_verdict;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  // Watchdog against a hung run.
  initial
  begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    print_verdict();
  end
  initial
  begin
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    t_reset();
    t_write();
    t_zero();
    t_rerst();
    print_verdict();
  end
endmodule : tb_secondary_blanking_turnoff_config
